// [dv/pci_link_properties.sv]
// concurrent checks on the bus link wires
`timescale 1ns/100ps
module pci_link_properties
   import pci_link_pkg::*;
(
   input wire logic               pci_clk,
   input wire logic               reset_n,
   input wire logic [CTL_W-1:0]   ctl_n,
   input wire logic [CTL_W-1:0]   dev_ctl_oe,
   input wire logic [CTL_W-1:0]   oth_ctl_oe,
   input wire logic [AD_W-1:0]    ad,
   input wire logic [BE_W-1:0]    cbe,
   input wire logic               par,
   input wire logic               dev_par_oe,
   input wire logic               dev_serr_n,
   input wire logic               dev_serr_oe,
   input wire logic [NUM_REQ-1:0] req_n,
   input wire logic [NUM_REQ-1:0] gnt_n
);
   default clocking @(posedge pci_clk); endclocking
   default disable iff (!reset_n);
   a_even_parity: assert property (dev_par_oe |-> ^{ad, cbe, par} == 1'b0)
      else $error("parity bit not even");
   a_serr_pull_low: assert property (dev_serr_oe |-> !dev_serr_n ##1 !dev_serr_oe)
      else $error("error line driven high or held");
   a_frame_one_phase: assert property (!ctl_n[CTL_FRAME]
      && dev_ctl_oe[CTL_FRAME] |=> ctl_n[CTL_FRAME] && !ctl_n[CTL_IRDY])
      else $error("frame or irdy wrong after address phase");
   a_master_data_done: assert property (dev_ctl_oe[CTL_IRDY] && !ctl_n[CTL_IRDY]
      && !ctl_n[CTL_TRDY] |=> !dev_ctl_oe[CTL_IRDY])
      else $error("master held irdy after completion");
   a_master_stop_end: assert property (dev_ctl_oe[CTL_IRDY] && !ctl_n[CTL_IRDY]
      && !ctl_n[CTL_STOP] |=> !dev_ctl_oe[CTL_IRDY])
      else $error("master kept cycle after stop");
   a_target_data_done: assert property (dev_ctl_oe[CTL_TRDY] && !ctl_n[CTL_TRDY]
      && !ctl_n[CTL_IRDY] |=> !dev_ctl_oe[CTL_TRDY])
      else $error("target held trdy after completion");
   a_irdy_as_input: assert property (oth_ctl_oe[CTL_IRDY] |-> !dev_ctl_oe[CTL_IRDY])
      else $error("irdy driven while target");
   a_trdy_as_input: assert property (oth_ctl_oe[CTL_TRDY] |-> !dev_ctl_oe[CTL_TRDY])
      else $error("trdy driven while master");
   a_grant_release: assert property (!gnt_n[0] && req_n[0] |=> gnt_n[0])
      else $error("grant kept without request");
endmodule // pci_link_properties

// [dv/tb.sv]
// self-checking bench joining both ends of the bus link
`timescale 1ns/100ps
module tb;
   import pci_link_pkg::*;
   logic        ref_clk = 0, pci_clk = 0, reset_n = 0;
   logic        ds = 0, dw = 0, dpe = 1, dtr = 1, dts = 0, dlc = 0, os = 0, ow = 0, ol = 0;
   logic        ocl = 0, otr = 1, ots = 0;
   logic [31:0] da = 0, dd = 0, dq = 32'h0bad_f00d, oa = 0, od = 0, oq = 32'h1234_5678;
   logic        db, dn, dst, dlk, dcl, dpr, ob, on, ost, dtwp, dtrp, otwp;
   logic [3:0]  be = 4'h7;
   logic [31:0] drd, dta, dtw, ord, otw;
   int          errors = 0, checks = 0, cyc = 0, perrs = 0, strobes = 0;
   initial forever #5 ref_clk = ~ref_clk;
   initial forever #62.5 pci_clk = ~pci_clk;
   pci_link_if link (.pci_clk(pci_clk));
   pci_dev_end pci_dev_end_i (.ref_clk, .reset_n, .link(link.dev), .mst_start(ds),
      .mst_write(dw), .mst_addr(da), .mst_wdata(dd), .mst_be(be), .mst_busy(db),
      .mst_done(dn), .mst_stopped(dst), .mst_rdata(drd), .par_chk_en(dpe), .tgt_ready(dtr),
      .tgt_stop(dts), .tgt_rdata(dq), .tgt_wr(dtwp), .tgt_rd(dtrp), .tgt_addr(dta),
      .tgt_wdata(dtw),
      .locked(dlk), .par_err(dpr), .local_cycle(dlc), .local_claim(dcl));
   pci_oth_end pci_oth_end_i (.ref_clk, .reset_n, .link(link.oth), .ext_start(os),
      .ext_write(ow), .ext_lock(ol), .ext_addr(oa), .ext_wdata(od), .ext_be(be),
      .ext_busy(ob), .ext_done(on), .ext_stopped(ost), .ext_rdata(ord), .claim_local(ocl),
      .tgt_ready(otr), .tgt_stop(ots), .tgt_rdata(oq), .tgt_wr(otwp), .tgt_wdata(otw));
   pci_link_properties pci_link_properties_i (.pci_clk, .reset_n, .ctl_n(link.ctl_n),
      .dev_ctl_oe(link.dev_ctl_oe), .oth_ctl_oe(link.oth_ctl_oe), .ad(link.ad),
      .cbe(link.cbe), .par(link.par), .dev_par_oe(link.dev_par_oe),
      .dev_serr_n(link.dev_serr_n), .dev_serr_oe(link.dev_serr_oe), .req_n(link.req_n),
      .gnt_n(link.gnt_n));
   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // transfer started by the bridge end
   task automatic dxfer(logic w, logic [31:0] a, logic [31:0] d);
      @(negedge ref_clk); ds = 1; dw = w; da = a; dd = d;
      @(negedge ref_clk); ds = 0;
      while (dn !== 1'b1) @(negedge ref_clk);
   endtask
   // transfer started by the external agent
   task automatic oxfer(logic w, logic [31:0] a, logic [31:0] d);
      @(negedge ref_clk); os = 1; ow = w; oa = a; od = d;
      @(negedge ref_clk); os = 0;
      while (on !== 1'b1) @(negedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   // pulses counted on the falling edge, away from the rising launching edge
   always @(negedge ref_clk) begin
      if (dpr === 1'b1) perrs++;
      if (dtwp === 1'b1 || dtrp === 1'b1 || otwp === 1'b1) strobes++;
   end
   initial begin
      repeat (3) @(negedge ref_clk);
      reset_n = 1;
      dxfer(1, 32'h2000_0040, 32'hcafe_0001);
      cmp("oth wdata", 32'hcafe_0001, otw);
      cmp("dev busy", 0, {31'h0, db});
      dxfer(0, 32'h2000_0044, 0);
      cmp("dev rdata", oq, drd);
      ol = 1;
      oxfer(1, 32'h1000_0080, 32'h5a5a_a5a5);
      cmp("dev wdata", 32'h5a5a_a5a5, dtw);
      cmp("dev addr", 32'h1000_0080, dta);
      cmp("locked", 1, {31'h0, dlk});
      cmp("oth busy", 0, {31'h0, ob});
      ol = 0;
      oxfer(0, 32'h1000_0084, 0);
      cmp("oth rdata", dq, ord);
      cmp("unlocked", 0, {31'h0, dlk});
      cmp("parity errors", 0, perrs);
      otr = 0; ots = 1;
      dxfer(1, 32'h2000_0048, 32'h0000_0001);
      cmp("dev stopped", 1, {31'h0, dst});
      otr = 1; ots = 0; dtr = 0; dts = 1;
      oxfer(1, 32'h1000_0088, 32'h0000_0002);
      cmp("oth stopped", 1, {31'h0, ost});
      dtr = 1; dts = 0; dlc = 1; ocl = 1;
      repeat (30) @(negedge ref_clk);
      cmp("local claim", 1, {31'h0, dcl});
      ocl = 0;
      repeat (30) @(negedge ref_clk);
      cmp("local release", 0, {31'h0, dcl});
      dlc = 0;
      ocl = 1;
      repeat (30) @(negedge ref_clk);
      cmp("grant 2", 3, {29'h0, link.gnt_n});
      ocl = 0;
      repeat (30) @(negedge ref_clk);
      cmp("grant off", 7, {29'h0, link.gnt_n});
      cmp("target strobes", 3, strobes);
      finish_test();
   end
endmodule // tb

// [logic/pci_dev_end.sv]
// bridge end of the bus link: master, target, lock, parity, error, arbiter
// How it works
// - as master, drive irdy when data phase completable
// - read irdy: master takes data next edge
// - write irdy only with valid data driven
// - as target, sample irdy from master
// - lock low at cycle start: enter locked
// - lock high at new cycle start: leave locked
// - even parity over ad and cbe
// - master checks read data parity when enabled
// - target checks write address, write data parity
// - masters 0 and 1 request on own lines
// - master 2 requests on shared line
// - local slave claims shared line in local cycles
// - stop: master ends at next edge
// - stop carries disconnect, retry, abort
// - system error only pulled low, open drain
// - as target, drive trdy when completable
// - read trdy only with valid data driven
// - write trdy: target accepts present data
// - as master, sample trdy from target
// - arbiter grants each requester separately
// - frame driven as master, sampled as target
`timescale 1ns/100ps
module pci_dev_end
   import pci_link_pkg::*;
#(
   parameter logic [AD_W-1:0] TGT_BASE = 32'h1000_0000,
   parameter logic [AD_W-1:0] TGT_MASK = 32'hff00_0000
) (
   input  wire logic            ref_clk,
   input  wire logic            reset_n,
   pci_link_if.dev              link,
   input  wire logic            mst_start,
   input  wire logic            mst_write,
   input  wire logic [AD_W-1:0] mst_addr,
   input  wire logic [AD_W-1:0] mst_wdata,
   input  wire logic [BE_W-1:0] mst_be,
   output logic                 mst_busy,
   output logic                 mst_done,
   output logic                 mst_stopped,
   output logic [AD_W-1:0]      mst_rdata,
   input  wire logic            par_chk_en,
   input  wire logic            tgt_ready,
   input  wire logic            tgt_stop,
   input  wire logic [AD_W-1:0] tgt_rdata,
   output logic                 tgt_wr,
   output logic                 tgt_rd,
   output logic [AD_W-1:0]      tgt_addr,
   output logic [AD_W-1:0]      tgt_wdata,
   output logic                 locked,
   output logic                 par_err,
   input  wire logic            local_cycle,
   output logic                 local_claim
);
   typedef struct packed {
      logic [2:0]         ck;
      pins_t              p1;
      pins_t              p2;
      phase_t             st;
      logic               fprev;
      logic               pend;
      logic               wr;
      logic               twr_cyc;
      logic [AD_W-1:0]    addr;
      logic [AD_W-1:0]    wdat;
      logic [BE_W-1:0]    be;
      logic [CTL_W-1:0]   ctl_n;
      logic [CTL_W-1:0]   ctl_oe;
      logic [AD_W-1:0]    ad_o;
      logic               ad_oe;
      logic [BE_W-1:0]    cbe_o;
      logic               cbe_oe;
      logic               par_o;
      logic               par_oe;
      logic               serr_oe;
      logic [NUM_REQ-1:0] gnt_n;
      logic               done;
      logic               stopped;
      logic               perr;
      logic               twr;
      logic               trd;
      logic               locked;
      logic               claim;
      logic [AD_W-1:0]    rdata;
      logic [AD_W-1:0]    taddr;
      logic [AD_W-1:0]    twdat;
   } dev_st_t;

   dev_st_t            s_ff;
   dev_st_t            nxt_s;
   pins_t              p;
   logic               rise;
   logic               cyc_start;
   logic               bus_idle;
   logic               bad_par;
   logic [NUM_REQ-1:0] rq;
   logic [NUM_REQ-1:0] rq_on;

   // drop control, address, command and parity drives and return to idle
   function automatic dev_st_t release_bus(input dev_st_t x);
      x.ctl_n  = CTL_IDLE_N;
      x.ctl_oe = '0;
      x.ad_oe  = 1'b0;
      x.cbe_oe = 1'b0;
      x.par_oe = 1'b0;
      x.st     = ST_IDLE;
      return x;
   endfunction

   assign p         = s_ff.p2;
   assign rise      = s_ff.ck[1] & ~s_ff.ck[2];
   assign cyc_start = ~p.ctl[CTL_FRAME] & s_ff.fprev;
   assign bus_idle  = p.ctl[CTL_FRAME] & p.ctl[CTL_IRDY];
   assign bad_par   = par_chk_en & (p.par ^ even_par(p.ad, p.cbe));
   // shared line counts as a request only outside local cycles
   assign rq        = p.arb | {local_cycle, 2'b00};
   assign rq_on     = ~rq;

   always_comb begin
      nxt_s      = s_ff;
      nxt_s.ck   = {s_ff.ck[1:0], link.pci_clk};
      nxt_s.p1   = '{ctl: link.ctl_n, ad: link.ad, cbe: link.cbe, par: link.par,
                     arb: link.req_n};
      nxt_s.p2   = s_ff.p1;
      nxt_s.done = 1'b0;
      nxt_s.perr = 1'b0;
      nxt_s.twr  = 1'b0;
      nxt_s.trd  = 1'b0;
      if (mst_start && !s_ff.pend) begin
         nxt_s.pend = 1'b1;
         nxt_s.wr   = mst_write;
         nxt_s.addr = mst_addr;
         nxt_s.wdat = mst_wdata;
         nxt_s.be   = mst_be;
      end
      if (rise) begin
         nxt_s.serr_oe = 1'b0;
         nxt_s.fprev   = p.ctl[CTL_FRAME];
         if (cyc_start) begin
            nxt_s.locked = ~p.ctl[CTL_LOCK];
         end
         nxt_s.claim = local_cycle & ~p.arb[REQ_LOCAL];
         unique case (s_ff.st)
            ST_IDLE: begin
               if (s_ff.gnt_n != ARB_IDLE_N) begin
                  if ((~s_ff.gnt_n & rq_on) == '0) begin
                     nxt_s.gnt_n = ARB_IDLE_N;
                  end
               end else if (s_ff.pend && bus_idle) begin
                  nxt_s.ctl_n               = CTL_IDLE_N;
                  nxt_s.ctl_n[CTL_FRAME]    = 1'b0;
                  nxt_s.ctl_oe[CTL_FRAME]   = 1'b1;
                  nxt_s.ctl_oe[CTL_IRDY]    = 1'b1;
                  nxt_s.ad_o                = s_ff.addr;
                  nxt_s.ad_oe               = 1'b1;
                  nxt_s.cbe_o               = s_ff.wr ? CMD_MEM_WRITE : CMD_MEM_READ;
                  nxt_s.cbe_oe              = 1'b1;
                  nxt_s.par_o               = even_par(s_ff.addr, nxt_s.cbe_o);
                  nxt_s.par_oe              = 1'b1;
                  nxt_s.st                  = ST_M_ADDR;
               end else if (bus_idle && rq_on != '0) begin
                  // lowest numbered requester wins
                  nxt_s.gnt_n = ~(rq_on & (~rq_on + NUM_REQ'(1)));
               end
               // target claims a cycle started by someone else
               if (cyc_start && !s_ff.ctl_oe[CTL_FRAME] &&
                   (p.ad & TGT_MASK) == TGT_BASE &&
                   (p.cbe == CMD_MEM_WRITE || p.cbe == CMD_MEM_READ)) begin
                  nxt_s.twr_cyc          = (p.cbe == CMD_MEM_WRITE);
                  nxt_s.taddr            = p.ad;
                  nxt_s.ctl_oe[CTL_TRDY] = 1'b1;
                  nxt_s.ctl_oe[CTL_STOP] = 1'b1;
                  nxt_s.ctl_n[CTL_TRDY]  = 1'b1;
                  nxt_s.ctl_n[CTL_STOP]  = 1'b1;
                  nxt_s.st               = ST_T_DATA;
                  if (p.cbe == CMD_MEM_WRITE && bad_par) begin
                     nxt_s.perr    = 1'b1;
                     nxt_s.serr_oe = 1'b1;
                  end
               end
            end
            ST_M_ADDR: begin
               nxt_s.ctl_n[CTL_FRAME] = 1'b1;
               nxt_s.ctl_n[CTL_IRDY]  = 1'b0;
               nxt_s.cbe_o            = s_ff.be;
               if (s_ff.wr) begin
                  nxt_s.ad_o  = s_ff.wdat;
                  nxt_s.par_o = even_par(s_ff.wdat, s_ff.be);
               end else begin
                  nxt_s.ad_oe  = 1'b0;
                  nxt_s.par_oe = 1'b0;
               end
               nxt_s.st = ST_M_DATA;
            end
            ST_M_DATA: begin
               if (!p.ctl[CTL_TRDY]) begin
                  nxt_s      = release_bus(nxt_s);
                  nxt_s.done = 1'b1;
                  nxt_s.pend = 1'b0;
                  nxt_s.stopped = 1'b0;
                  if (!s_ff.wr) begin
                     nxt_s.rdata = p.ad;
                     if (bad_par) begin
                        nxt_s.perr    = 1'b1;
                        nxt_s.serr_oe = 1'b1;
                     end
                  end
               end else if (!p.ctl[CTL_STOP]) begin
                  nxt_s         = release_bus(nxt_s);
                  nxt_s.done    = 1'b1;
                  nxt_s.pend    = 1'b0;
                  nxt_s.stopped = 1'b1;
               end
            end
            ST_T_DATA: begin
               if (!s_ff.ctl_n[CTL_TRDY] && !p.ctl[CTL_IRDY]) begin
                  nxt_s = release_bus(nxt_s);
                  if (s_ff.twr_cyc) begin
                     nxt_s.twdat = p.ad;
                     nxt_s.twr   = 1'b1;
                     if (bad_par) begin
                        nxt_s.perr    = 1'b1;
                        nxt_s.serr_oe = 1'b1;
                     end
                  end else begin
                     nxt_s.trd = 1'b1;
                  end
               end else if (!s_ff.ctl_n[CTL_STOP]) begin
                  nxt_s = release_bus(nxt_s);
               end else if (!p.ctl[CTL_IRDY]) begin // reply once byte enables stand
                  nxt_s.ctl_n[CTL_TRDY] = ~tgt_ready;
                  nxt_s.ctl_n[CTL_STOP] = ~(tgt_stop & ~tgt_ready);
                  if (!s_ff.twr_cyc && tgt_ready) begin
                     nxt_s.ad_o   = tgt_rdata;
                     nxt_s.ad_oe  = 1'b1;
                     nxt_s.par_o  = even_par(tgt_rdata, p.cbe);
                     nxt_s.par_oe = 1'b1;
                  end
               end
            end
         endcase
      end
      if (!reset_n) begin
         nxt_s       = '0;
         nxt_s.st    = ST_IDLE;
         nxt_s.fprev = 1'b1;
         nxt_s.ck    = 3'h7; // no false edge after reset
         nxt_s.ctl_n = CTL_IDLE_N;
         nxt_s.gnt_n = ARB_IDLE_N;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_ff <= nxt_s;
   end

   assign link.dev_ctl_n   = s_ff.ctl_n;
   assign link.dev_ctl_oe  = s_ff.ctl_oe;
   assign link.dev_ad_o    = s_ff.ad_o;
   assign link.dev_ad_oe   = s_ff.ad_oe;
   assign link.dev_cbe_o   = s_ff.cbe_o;
   assign link.dev_cbe_oe  = s_ff.cbe_oe;
   assign link.dev_par_o   = s_ff.par_o;
   assign link.dev_par_oe  = s_ff.par_oe;
   assign link.dev_serr_n  = 1'b0;
   assign link.dev_serr_oe = s_ff.serr_oe;
   assign link.gnt_n       = s_ff.gnt_n;
   assign mst_busy         = s_ff.pend;
   assign mst_done         = s_ff.done;
   assign mst_stopped      = s_ff.stopped;
   assign mst_rdata        = s_ff.rdata;
   assign tgt_wr           = s_ff.twr;
   assign tgt_rd           = s_ff.trd;
   assign tgt_addr         = s_ff.taddr;
   assign tgt_wdata        = s_ff.twdat;
   assign locked           = s_ff.locked;
   assign par_err          = s_ff.perr;
   assign local_claim      = s_ff.claim;
endmodule // pci_dev_end

// [logic/pci_link_if.sv]
// bus wires between the two ends, with pull-up resolution
`timescale 1ns/100ps
interface pci_link_if (
   input wire logic pci_clk
);
   import pci_link_pkg::*;
   logic [CTL_W-1:0]   dev_ctl_n;
   logic [CTL_W-1:0]   dev_ctl_oe;
   logic [CTL_W-1:0]   oth_ctl_n;
   logic [CTL_W-1:0]   oth_ctl_oe;
   logic [CTL_W-1:0]   ctl_n;
   logic [AD_W-1:0]    dev_ad_o;
   logic [AD_W-1:0]    oth_ad_o;
   logic [AD_W-1:0]    ad;
   logic               dev_ad_oe;
   logic               oth_ad_oe;
   logic [BE_W-1:0]    dev_cbe_o;
   logic [BE_W-1:0]    oth_cbe_o;
   logic [BE_W-1:0]    cbe;
   logic               dev_cbe_oe;
   logic               oth_cbe_oe;
   logic               dev_par_o;
   logic               dev_par_oe;
   logic               oth_par_o;
   logic               oth_par_oe;
   logic               par;
   logic               dev_serr_n;
   logic               dev_serr_oe;
   logic               serr_n;
   logic [NUM_REQ-1:0] req_n;
   logic [NUM_REQ-1:0] gnt_n;

   // undriven lines float high
   always_comb begin
      for (int i = 0; i < CTL_W; i++) begin
         ctl_n[i] = dev_ctl_oe[i] ? dev_ctl_n[i] : (oth_ctl_oe[i] ? oth_ctl_n[i] : 1'b1);
      end
      ad     = dev_ad_oe ? dev_ad_o : (oth_ad_oe ? oth_ad_o : '1);
      cbe    = dev_cbe_oe ? dev_cbe_o : (oth_cbe_oe ? oth_cbe_o : '1);
      par    = dev_par_oe ? dev_par_o : (oth_par_oe ? oth_par_o : 1'b1);
      serr_n = dev_serr_oe ? dev_serr_n : 1'b1;
   end

   modport dev (input pci_clk, ctl_n, ad, cbe, par, serr_n, req_n,
                output dev_ctl_n, dev_ctl_oe, dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe,
                dev_par_o, dev_par_oe, dev_serr_n, dev_serr_oe, gnt_n);
   modport oth (input pci_clk, ctl_n, ad, cbe, par, serr_n, gnt_n,
                output oth_ctl_n, oth_ctl_oe, oth_ad_o, oth_ad_oe, oth_cbe_o, oth_cbe_oe,
                oth_par_o, oth_par_oe, req_n);
endinterface // pci_link_if

// [logic/pci_link_pkg.sv]
// constants, types and helpers shared by both ends of the bus link
package pci_link_pkg;
   localparam int AD_W      = 32;
   localparam int BE_W      = 4;
   localparam int NUM_REQ   = 3;
   localparam int CTL_W     = 5;
   localparam int CTL_FRAME = 0;
   localparam int CTL_IRDY  = 1;
   localparam int CTL_TRDY  = 2;
   localparam int CTL_STOP  = 3;
   localparam int CTL_LOCK  = 4;
   localparam int REQ_LOCAL = 2;

   localparam logic [3:0]         CMD_MEM_READ  = 4'h6;
   localparam logic [3:0]         CMD_MEM_WRITE = 4'h7;
   localparam logic [CTL_W-1:0]   CTL_IDLE_N    = 5'h1f;
   localparam logic [NUM_REQ-1:0] ARB_IDLE_N    = 3'h7;

   typedef enum logic [1:0] {ST_IDLE, ST_M_ADDR, ST_M_DATA, ST_T_DATA} phase_t;

   typedef struct packed {
      logic [CTL_W-1:0]   ctl;
      logic [AD_W-1:0]    ad;
      logic [BE_W-1:0]    cbe;
      logic               par;
      logic [NUM_REQ-1:0] arb;
   } pins_t;

   // even parity over address/data and command/byte enables
   function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [BE_W-1:0] cbe);
      return ^{ad, cbe};
   endfunction
endpackage

// [logic/pci_oth_end.sv]
// external agent end of the bus link: requesting master and simple target
`timescale 1ns/100ps
module pci_oth_end
   import pci_link_pkg::*;
#(
   parameter int              MASTER_ID = 0,
   parameter logic [AD_W-1:0] TGT_BASE  = 32'h2000_0000,
   parameter logic [AD_W-1:0] TGT_MASK  = 32'hff00_0000
) (
   input  wire logic            ref_clk,
   input  wire logic            reset_n,
   pci_link_if.oth              link,
   input  wire logic            ext_start,
   input  wire logic            ext_write,
   input  wire logic            ext_lock,
   input  wire logic [AD_W-1:0] ext_addr,
   input  wire logic [AD_W-1:0] ext_wdata,
   input  wire logic [BE_W-1:0] ext_be,
   output logic                 ext_busy,
   output logic                 ext_done,
   output logic                 ext_stopped,
   output logic [AD_W-1:0]      ext_rdata,
   input  wire logic            claim_local,
   input  wire logic            tgt_ready,
   input  wire logic            tgt_stop,
   input  wire logic [AD_W-1:0] tgt_rdata,
   output logic                 tgt_wr,
   output logic [AD_W-1:0]      tgt_wdata
);
   localparam logic [NUM_REQ-1:0] ID_BIT = NUM_REQ'(1) << MASTER_ID;

   typedef struct packed {
      logic [2:0]         ck;
      pins_t              p1;
      pins_t              p2;
      phase_t             st;
      logic               fprev;
      logic               pend;
      logic               wr;
      logic               lk;
      logic               twr_cyc;
      logic [AD_W-1:0]    addr;
      logic [AD_W-1:0]    wdat;
      logic [BE_W-1:0]    be;
      logic [CTL_W-1:0]   ctl_n;
      logic [CTL_W-1:0]   ctl_oe;
      logic [AD_W-1:0]    ad_o;
      logic               ad_oe;
      logic [BE_W-1:0]    cbe_o;
      logic               cbe_oe;
      logic               par_o;
      logic               par_oe;
      logic [NUM_REQ-1:0] req_n;
      logic               done;
      logic               stopped;
      logic               twr;
      logic [AD_W-1:0]    rdata;
      logic [AD_W-1:0]    twdat;
   } oth_st_t;

   oth_st_t s_ff;
   oth_st_t nxt_s;
   pins_t   p;
   logic    rise;

   function automatic oth_st_t release_bus(input oth_st_t x);
      x.ctl_n  = CTL_IDLE_N;
      x.ctl_oe = '0;
      x.ad_oe  = 1'b0;
      x.cbe_oe = 1'b0;
      x.par_oe = 1'b0;
      x.st     = ST_IDLE;
      return x;
   endfunction

   assign p    = s_ff.p2;
   assign rise = s_ff.ck[1] & ~s_ff.ck[2];

   always_comb begin
      nxt_s       = s_ff;
      nxt_s.ck    = {s_ff.ck[1:0], link.pci_clk};
      nxt_s.p1    = '{ctl: link.ctl_n, ad: link.ad, cbe: link.cbe, par: link.par,
                      arb: link.gnt_n};
      nxt_s.p2    = s_ff.p1;
      nxt_s.done  = 1'b0;
      nxt_s.twr   = 1'b0;
      // own request line, shared line doubles as local claim
      nxt_s.req_n = ~(({NUM_REQ{s_ff.pend}} & ID_BIT) | {claim_local, 2'b00});
      if (ext_start && !s_ff.pend) begin
         nxt_s.pend = 1'b1;
         nxt_s.wr   = ext_write;
         nxt_s.lk   = ext_lock;
         nxt_s.addr = ext_addr;
         nxt_s.wdat = ext_wdata;
         nxt_s.be   = ext_be;
      end
      if (rise) begin
         nxt_s.fprev = p.ctl[CTL_FRAME];
         unique case (s_ff.st)
            ST_IDLE: begin
               if (s_ff.pend && (p.arb & ID_BIT) == '0 &&
                   p.ctl[CTL_FRAME] && p.ctl[CTL_IRDY]) begin
                  nxt_s.ctl_n            = CTL_IDLE_N;
                  nxt_s.ctl_n[CTL_FRAME] = 1'b0;
                  nxt_s.ctl_n[CTL_LOCK]  = ~s_ff.lk;
                  nxt_s.ctl_oe[CTL_FRAME] = 1'b1;
                  nxt_s.ctl_oe[CTL_IRDY]  = 1'b1;
                  nxt_s.ctl_oe[CTL_LOCK]  = 1'b1;
                  nxt_s.ad_o   = s_ff.addr;
                  nxt_s.ad_oe  = 1'b1;
                  nxt_s.cbe_o  = s_ff.wr ? CMD_MEM_WRITE : CMD_MEM_READ;
                  nxt_s.cbe_oe = 1'b1;
                  nxt_s.par_o  = even_par(s_ff.addr, nxt_s.cbe_o);
                  nxt_s.par_oe = 1'b1;
                  nxt_s.st     = ST_M_ADDR;
               end else if (!p.ctl[CTL_FRAME] && s_ff.fprev &&
                            (p.ad & TGT_MASK) == TGT_BASE &&
                            (p.cbe == CMD_MEM_WRITE || p.cbe == CMD_MEM_READ)) begin
                  nxt_s.twr_cyc          = (p.cbe == CMD_MEM_WRITE);
                  nxt_s.ctl_oe[CTL_TRDY] = 1'b1;
                  nxt_s.ctl_oe[CTL_STOP] = 1'b1;
                  nxt_s.st               = ST_T_DATA;
               end
            end
            ST_M_ADDR: begin
               nxt_s.ctl_n[CTL_FRAME] = 1'b1;
               nxt_s.ctl_n[CTL_IRDY]  = 1'b0;
               nxt_s.cbe_o            = s_ff.be;
               if (s_ff.wr) begin
                  nxt_s.ad_o  = s_ff.wdat;
                  nxt_s.par_o = even_par(s_ff.wdat, s_ff.be);
               end else begin
                  nxt_s.ad_oe  = 1'b0;
                  nxt_s.par_oe = 1'b0;
               end
               nxt_s.st = ST_M_DATA;
            end
            ST_M_DATA: begin
               if (!p.ctl[CTL_TRDY] || !p.ctl[CTL_STOP]) begin
                  nxt_s         = release_bus(nxt_s);
                  nxt_s.done    = 1'b1;
                  nxt_s.pend    = 1'b0;
                  nxt_s.stopped = p.ctl[CTL_TRDY];
                  if (!s_ff.wr && !p.ctl[CTL_TRDY]) begin
                     nxt_s.rdata = p.ad;
                  end
               end
            end
            ST_T_DATA: begin
               if (!s_ff.ctl_n[CTL_TRDY] && !p.ctl[CTL_IRDY]) begin
                  nxt_s = release_bus(nxt_s);
                  if (s_ff.twr_cyc) begin
                     nxt_s.twdat = p.ad;
                     nxt_s.twr   = 1'b1;
                  end
               end else if (!s_ff.ctl_n[CTL_STOP]) begin
                  nxt_s = release_bus(nxt_s);
               end else if (!p.ctl[CTL_IRDY]) begin // reply once byte enables stand
                  nxt_s.ctl_n[CTL_TRDY] = ~tgt_ready;
                  nxt_s.ctl_n[CTL_STOP] = ~(tgt_stop & ~tgt_ready);
                  if (!s_ff.twr_cyc && tgt_ready) begin
                     nxt_s.ad_o   = tgt_rdata;
                     nxt_s.ad_oe  = 1'b1;
                     nxt_s.par_o  = even_par(tgt_rdata, p.cbe);
                     nxt_s.par_oe = 1'b1;
                  end
               end
            end
         endcase
      end
      if (!reset_n) begin
         nxt_s       = '0;
         nxt_s.st    = ST_IDLE;
         nxt_s.fprev = 1'b1;
         nxt_s.ck    = 3'h7; // no false edge after reset
         nxt_s.ctl_n = CTL_IDLE_N;
         nxt_s.req_n = ARB_IDLE_N;
      end
   end

   always_ff @(posedge ref_clk) begin
      s_ff <= nxt_s;
   end

   assign link.oth_ctl_n  = s_ff.ctl_n;
   assign link.oth_ctl_oe = s_ff.ctl_oe;
   assign link.oth_ad_o   = s_ff.ad_o;
   assign link.oth_ad_oe  = s_ff.ad_oe;
   assign link.oth_cbe_o  = s_ff.cbe_o;
   assign link.oth_cbe_oe = s_ff.cbe_oe;
   assign link.oth_par_o  = s_ff.par_o;
   assign link.oth_par_oe = s_ff.par_oe;
   assign link.req_n      = s_ff.req_n;
   assign ext_busy        = s_ff.pend;
   assign ext_done        = s_ff.done;
   assign ext_stopped     = s_ff.stopped;
   assign ext_rdata       = s_ff.rdata;
   assign tgt_wr          = s_ff.twr;
   assign tgt_wdata       = s_ff.twdat;
endmodule // pci_oth_end
